// ===== hw/mrs_map.svh
// constants of the slave message handler: function codes, error codes,
// buffer limits, register space split and crc parameters
// assumes inclusion by bare name from any design file that needs them
`ifndef MRS_MAP_SVH
`define MRS_MAP_SVH

// ------------------------------------------------------------------
// function and error codes
// ------------------------------------------------------------------
`define MRS_FC_READ     8'h03
`define MRS_FC_LOOP     8'h08
`define MRS_FC_WRITE    8'h10
`define MRS_FC_ERR_BIT  8'h80
`define MRS_ERR_NONE    8'h00
`define MRS_ERR_FUNC    8'h01
`define MRS_ERR_ADDR    8'h02
`define MRS_ERR_QTY     8'h03

// ------------------------------------------------------------------
// message layout and limits
// ------------------------------------------------------------------
`define MRS_BCAST_ADDR  8'h00
`define MRS_MAX_QTY     16'h0010
`define MRS_BUF_LEN     6'h29
`define MRS_MIN_LEN     6'h04
`define MRS_READ_LEN    6'h08
`define MRS_LOOP_LEN    6'h08
`define MRS_WR_HDR_LEN  9'h009
`define MRS_WR_RSP_LEN  6'h06
`define MRS_ERR_RSP_LEN 6'h03
`define MRS_RD_HDR_LEN  6'h03
`define MRS_WR_DATA_POS 6'h07

// ------------------------------------------------------------------
// register space split and crc
// ------------------------------------------------------------------
`define MRS_MON_BASE    16'h0020
`define MRS_CRC_INIT    16'hFFFF
`define MRS_CRC_POLY    16'hA001

`endif

// ===== hw/mrs_pkg.sv
// types shared by the slave message handler, the bus master model and the bench
// assumes nothing beyond a systemverilog compiler
package mrs_pkg;

    typedef enum logic [1:0] {
        MRS_SPACE_CMD,
        MRS_SPACE_MON,
        MRS_SPACE_BCAST
    } mrs_space_e;

    typedef enum logic [2:0] {
        MRS_S_RX,
        MRS_S_EVAL,
        MRS_S_RD,
        MRS_S_RD_WAIT,
        MRS_S_WR,
        MRS_S_SEND,
        MRS_S_CRC_HI
    } mrs_state_e;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } mrs_byte_s;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        need_enter;
        mrs_space_e  space;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mrs_reg_req_s;

endpackage

// ===== hw/mrs_crc16.sv
// crc-16 accumulator, reflected polynomial, one byte per enabled cycle
// assumes clear and enable come from logic on the same clock
`timescale 1ns/100ps
`include "mrs_map.svh"

module mrs_crc16 (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clr,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc
);

    logic [15:0] crc_q;
    logic [15:0] crc_d;
    logic [15:0] c;

    always_comb
    begin
        c = crc_q ^ {8'h00, data};
        for (int i = 0; i < 8; i++)
        begin
            c = c[0] ? ((c >> 1) ^ `MRS_CRC_POLY) : (c >> 1);
        end
        if (clr)
            crc_d = `MRS_CRC_INIT;
        else if (en)
            crc_d = c;
        else
            crc_d = crc_q;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            crc_q <= `MRS_CRC_INIT;
        else
            crc_q <= crc_d;
    end

    assign crc = crc_q;

endmodule

// ===== hw/mrs_msg_handler.sv
// slave message handler: read registers, loopback, write registers
// assumes a framing layer that delivers each received frame byte by
// byte with last on the final crc byte, and a register space that
// answers a read in the same cycle as the read strobe
`timescale 1ns/100ps
`include "mrs_map.svh"

module mrs_msg_handler (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic [7:0]            slave_addr,
    input  wire logic                  enter_function_select,
    input  wire logic                  enter_cmd,
    input  wire mrs_pkg::mrs_byte_s    rx,
    input  wire logic                  tx_ready,
    output mrs_pkg::mrs_byte_s         tx,
    output mrs_pkg::mrs_reg_req_s      reg_req,
    input  wire logic [15:0]           reg_rdata,
    input  wire logic                  reg_err,
    output logic                       param_dirty
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_s;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_q <= 1'b0;
            rst_n_s    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_s    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    mrs_pkg::mrs_state_e   st_q,      st_d;
    logic [7:0]            buf_q [`MRS_BUF_LEN];
    logic [7:0]            buf_d [`MRS_BUF_LEN];
    logic [5:0]            len_q,     len_d;
    logic                  ovf_q,     ovf_d;
    logic [4:0]            n_q,       n_d;
    logic [4:0]            qty_q,     qty_d;
    logic [15:0]           start_q,   start_d;
    logic                  bcast_q,   bcast_d;
    logic [5:0]            tx_len_q,  tx_len_d;
    logic [5:0]            idx_q,     idx_d;
    logic                  add_crc_q, add_crc_d;
    logic                  dirty_q,   dirty_d;
    mrs_pkg::mrs_byte_s    tx_q,      tx_d;
    mrs_pkg::mrs_reg_req_s reg_q,     reg_d;

    logic        crc_clr;
    logic        crc_en;
    logic [7:0]  crc_byte;
    logic [15:0] crc;

    mrs_crc16 u_crc (
        .clk   (clk),
        .rst_n (rst_n_s),
        .clr   (crc_clr),
        .en    (crc_en),
        .data  (crc_byte),
        .crc   (crc)
    );

    logic [15:0] qty16;
    logic [15:0] last_addr;
    logic [15:0] cur_addr;
    logic [5:0]  wo;
    logic [8:0]  wr_len;
    logic        qty_ok;
    logic        frame_ok;
    logic        tx_free;
    logic [7:0]  err;
    logic [7:0]  wr_hi_byte;

    assign qty16     = {buf_q[4], buf_q[5]};
    assign qty_ok    = (qty16 != 16'h0000) && (qty16 <= `MRS_MAX_QTY);
    assign last_addr = {buf_q[2], buf_q[3]} + qty16 - 16'h0001;
    assign cur_addr  = start_q + {11'h000, n_q};
    assign wo        = {n_q, 1'b0};
    assign wr_len    = `MRS_WR_HDR_LEN + {1'b0, buf_q[6]};
    assign tx_free   = !tx_q.valid || tx_ready;
    assign wr_hi_byte = buf_q[`MRS_WR_DATA_POS + wo];
    // crc over a whole good frame, checksum included, leaves zero
    assign frame_ok  = !ovf_q && (crc == 16'h0000)
                       && (len_q >= `MRS_MIN_LEN)
                       && ((buf_q[0] == slave_addr)
                           || (buf_q[0] == `MRS_BCAST_ADDR));

    // ------------------------------------------------------------------
    // message sequencing
    // ------------------------------------------------------------------
    always_comb
    begin
        st_d      = st_q;
        buf_d     = buf_q;
        len_d     = len_q;
        ovf_d     = ovf_q;
        n_d       = n_q;
        qty_d     = qty_q;
        start_d   = start_q;
        bcast_d   = bcast_q;
        tx_len_d  = tx_len_q;
        idx_d     = idx_q;
        add_crc_d = add_crc_q;
        dirty_d   = dirty_q & ~enter_cmd;
        tx_d      = tx_q;
        reg_d     = reg_q;
        reg_d.rd  = 1'b0;
        reg_d.wr  = 1'b0;
        crc_clr   = 1'b0;
        crc_en    = 1'b0;
        crc_byte  = rx.data;
        err       = `MRS_ERR_NONE;
        if (tx_ready)
            tx_d.valid = 1'b0;
        unique case (st_q)
            mrs_pkg::MRS_S_RX:
            begin
                if (rx.valid)
                begin
                    if (len_q < `MRS_BUF_LEN)
                    begin
                        buf_d[len_q] = rx.data;
                        len_d        = len_q + 6'h01;
                    end
                    else
                        ovf_d = 1'b1;
                    crc_en = 1'b1;
                    if (rx.last)
                        st_d = mrs_pkg::MRS_S_EVAL;
                end
            end
            mrs_pkg::MRS_S_EVAL:
            begin
                crc_clr = 1'b1;
                n_d     = 5'h00;
                idx_d   = 6'h00;
                len_d   = 6'h00;
                ovf_d   = 1'b0;
                st_d    = mrs_pkg::MRS_S_RX;
                bcast_d = (buf_q[0] == `MRS_BCAST_ADDR);
                start_d = {buf_q[2], buf_q[3]};
                qty_d   = qty16[4:0];
                if (frame_ok)
                begin
                    case (buf_q[1])
                        `MRS_FC_LOOP:
                        begin
                            if (!bcast_d)
                            begin
                                tx_len_d  = len_q;
                                add_crc_d = 1'b0;
                                st_d      = mrs_pkg::MRS_S_SEND;
                            end
                        end
                        `MRS_FC_READ:
                        begin
                            if (!qty_ok || len_q != `MRS_READ_LEN)
                                err = `MRS_ERR_QTY;
                            else if (!bcast_d)
                            begin
                                buf_d[2] = {qty16[6:0], 1'b0};
                                st_d     = mrs_pkg::MRS_S_RD;
                            end
                        end
                        `MRS_FC_WRITE:
                        begin
                            if (!qty_ok || buf_q[6] != {qty16[6:0], 1'b0}
                                || {3'h0, len_q} != wr_len)
                                err = `MRS_ERR_QTY;
                            else if (last_addr >= `MRS_MON_BASE)
                                err = `MRS_ERR_ADDR;
                            else
                                st_d = mrs_pkg::MRS_S_WR;
                        end
                        default:
                            err = `MRS_ERR_FUNC;
                    endcase
                    if (err != `MRS_ERR_NONE && !bcast_d)
                    begin
                        buf_d[1]  = buf_q[1] | `MRS_FC_ERR_BIT;
                        buf_d[2]  = err;
                        tx_len_d  = `MRS_ERR_RSP_LEN;
                        add_crc_d = 1'b1;
                        st_d      = mrs_pkg::MRS_S_SEND;
                    end
                end
            end
            mrs_pkg::MRS_S_RD:
            begin
                reg_d.rd    = 1'b1;
                reg_d.addr  = cur_addr;
                reg_d.space = (cur_addr < `MRS_MON_BASE) ?
                              mrs_pkg::MRS_SPACE_CMD :
                              mrs_pkg::MRS_SPACE_MON;
                st_d        = mrs_pkg::MRS_S_RD_WAIT;
            end
            mrs_pkg::MRS_S_RD_WAIT:
            begin
                if (reg_err)
                begin
                    buf_d[1]  = buf_q[1] | `MRS_FC_ERR_BIT;
                    buf_d[2]  = `MRS_ERR_ADDR;
                    tx_len_d  = `MRS_ERR_RSP_LEN;
                    add_crc_d = 1'b1;
                    st_d      = mrs_pkg::MRS_S_SEND;
                end
                else
                begin
                    buf_d[`MRS_RD_HDR_LEN + wo]         = reg_rdata[15:8];
                    buf_d[`MRS_RD_HDR_LEN + wo + 6'h01] = reg_rdata[7:0];
                    n_d = n_q + 5'h01;
                    if (n_d == qty_q)
                    begin
                        tx_len_d  = `MRS_RD_HDR_LEN + {qty_q, 1'b0};
                        add_crc_d = 1'b1;
                        st_d      = mrs_pkg::MRS_S_SEND;
                    end
                    else
                        st_d = mrs_pkg::MRS_S_RD;
                end
            end
            mrs_pkg::MRS_S_WR:
            begin
                reg_d.wr         = 1'b1;
                reg_d.addr       = cur_addr;
                reg_d.wdata      = {wr_hi_byte,
                                    buf_q[`MRS_WR_DATA_POS + wo + 6'h01]};
                reg_d.space      = bcast_q ? mrs_pkg::MRS_SPACE_BCAST :
                                   mrs_pkg::MRS_SPACE_CMD;
                reg_d.need_enter = enter_function_select;
                if (enter_function_select)
                    dirty_d = 1'b1;
                n_d = n_q + 5'h01;
                if (n_d == qty_q)
                begin
                    if (bcast_q)
                        st_d = mrs_pkg::MRS_S_RX;
                    else
                    begin
                        tx_len_d  = `MRS_WR_RSP_LEN;
                        add_crc_d = 1'b1;
                        st_d      = mrs_pkg::MRS_S_SEND;
                    end
                end
            end
            mrs_pkg::MRS_S_SEND:
            begin
                if (tx_free)
                begin
                    if (idx_q < tx_len_q)
                    begin
                        tx_d.valid = 1'b1;
                        tx_d.data  = buf_q[idx_q];
                        tx_d.last  = (idx_q == tx_len_q - 6'h01)
                                     && !add_crc_q;
                        crc_en     = 1'b1;
                        crc_byte   = buf_q[idx_q];
                        idx_d      = idx_q + 6'h01;
                        if (tx_d.last)
                        begin
                            crc_clr = 1'b1;
                            st_d    = mrs_pkg::MRS_S_RX;
                        end
                    end
                    else
                    begin
                        tx_d  = '{valid: 1'b1, last: 1'b0,
                                  data: crc[7:0]};
                        st_d  = mrs_pkg::MRS_S_CRC_HI;
                    end
                end
            end
            mrs_pkg::MRS_S_CRC_HI:
            begin
                if (tx_free)
                begin
                    tx_d    = '{valid: 1'b1, last: 1'b1,
                                data: crc[15:8]};
                    crc_clr = 1'b1;
                    st_d    = mrs_pkg::MRS_S_RX;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            st_q      <= mrs_pkg::MRS_S_RX;
            for (int i = 0; i < `MRS_BUF_LEN; i++)
                buf_q[i] <= 8'h00;
            len_q     <= 6'h00;
            ovf_q     <= 1'b0;
            n_q       <= 5'h00;
            qty_q     <= 5'h00;
            start_q   <= 16'h0000;
            bcast_q   <= 1'b0;
            tx_len_q  <= 6'h00;
            idx_q     <= 6'h00;
            add_crc_q <= 1'b0;
            dirty_q   <= 1'b0;
            tx_q      <= '0;
            reg_q     <= '0;
        end
        else
        begin
            st_q      <= st_d;
            buf_q     <= buf_d;
            len_q     <= len_d;
            ovf_q     <= ovf_d;
            n_q       <= n_d;
            qty_q     <= qty_d;
            start_q   <= start_d;
            bcast_q   <= bcast_d;
            tx_len_q  <= tx_len_d;
            idx_q     <= idx_d;
            add_crc_q <= add_crc_d;
            dirty_q   <= dirty_d;
            tx_q      <= tx_d;
            reg_q     <= reg_d;
        end
    end

    assign tx          = tx_q;
    assign reg_req     = reg_q;
    assign param_dirty = dirty_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_rd_step;
        reg_q.rd ##2 reg_q.rd;
    endsequence

    property p_rd_ascend;
        @(posedge clk) disable iff (!rst_n_s)
        s_rd_step |-> reg_q.addr == $past(reg_q.addr, 2) + 16'h0001;
    endproperty
    a_rd_ascend: assert property (p_rd_ascend)
        else $error("read addresses not ascending");

    property p_rd_wait;
        @(posedge clk) disable iff (!rst_n_s)
        reg_q.rd |-> st_q == mrs_pkg::MRS_S_RD_WAIT && !reg_q.wr;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read strobe outside read wait");

    property p_wr_ascend;
        @(posedge clk) disable iff (!rst_n_s)
        reg_q.wr && $past(reg_q.wr) |->
            reg_q.addr == $past(reg_q.addr) + 16'h0001;
    endproperty
    a_wr_ascend: assert property (p_wr_ascend)
        else $error("write addresses not ascending");

    property p_wr_hi_first;
        @(posedge clk) disable iff (!rst_n_s)
        st_q == mrs_pkg::MRS_S_WR |=>
            reg_q.wr && reg_q.wdata[15:8] == $past(wr_hi_byte);
    endproperty
    a_wr_hi_first: assert property (p_wr_hi_first)
        else $error("write word byte order wrong");

    property p_wr_space;
        @(posedge clk) disable iff (!rst_n_s)
        reg_q.wr |-> reg_q.space != mrs_pkg::MRS_SPACE_MON
                     && reg_q.addr < `MRS_MON_BASE;
    endproperty
    a_wr_space: assert property (p_wr_space)
        else $error("write reached monitor space");

    property p_dirty;
        @(posedge clk) disable iff (!rst_n_s)
        st_q == mrs_pkg::MRS_S_WR && enter_function_select |=>
            param_dirty && reg_q.need_enter;
    endproperty
    a_dirty: assert property (p_dirty)
        else $error("held write did not mark pending enter");

    sequence s_loop_start;
        st_q == mrs_pkg::MRS_S_EVAL && st_d == mrs_pkg::MRS_S_SEND
        && buf_q[1] == `MRS_FC_LOOP;
    endsequence

    property p_loop_echo;
        @(posedge clk) disable iff (!rst_n_s)
        s_loop_start |=> tx_len_q == $past(len_q) && !add_crc_q;
    endproperty
    a_loop_echo: assert property (p_loop_echo)
        else $error("loopback length or crc wrong");

    property p_err_reply;
        @(posedge clk) disable iff (!rst_n_s)
        st_q == mrs_pkg::MRS_S_EVAL && err != `MRS_ERR_NONE && !bcast_d
        |=> buf_q[1][7] && buf_q[2] == $past(err)
            && tx_len_q == `MRS_ERR_RSP_LEN && add_crc_q;
    endproperty
    a_err_reply: assert property (p_err_reply)
        else $error("error reply malformed");

    property p_rd_count;
        @(posedge clk) disable iff (!rst_n_s)
        st_q == mrs_pkg::MRS_S_RD_WAIT && st_d == mrs_pkg::MRS_S_SEND
        && !reg_err |=> buf_q[2] == {2'b00, qty_q, 1'b0};
    endproperty
    a_rd_count: assert property (p_rd_count)
        else $error("read byte count wrong");

    property p_crc_tail;
        @(posedge clk) disable iff (!rst_n_s)
        st_q == mrs_pkg::MRS_S_CRC_HI && tx_free |=>
            tx_q.valid && tx_q.last && tx_q.data == $past(crc[15:8]);
    endproperty
    a_crc_tail: assert property (p_crc_tail)
        else $error("crc tail byte wrong");

endmodule

// ===== verif/mrs_master_model.sv
// bus master model: frames commands with crc, collects and checks replies
// assumes the handler's clock; drives its inputs at the rising edge
`timescale 1ns/100ps

module mrs_master_model (
    input  wire logic               clk,
    output mrs_pkg::mrs_byte_s      rx,
    output logic                    tx_ready,
    input  wire mrs_pkg::mrs_byte_s tx
);
    logic [7:0] sent[$];
    logic [7:0] resp[$];
    logic       slow;
    logic       crc_ok;

    initial
    begin
        rx = '0;
        tx_ready = 1'b0;
        slow = 1'b0;
        crc_ok = 1'b0;
    end

    // a slow master takes a byte only every other cycle
    always @(posedge clk)
        tx_ready <= slow ? ~tx_ready : 1'b1;

    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i])
        begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction

    task automatic transact(input logic [7:0] cmd[$], input int wait_max);
        logic [15:0] c;
        logic [7:0]  body[$];
        c = crc16(cmd);
        sent = cmd;
        sent.push_back(c[7:0]);
        sent.push_back(c[15:8]);
        resp.delete();
        foreach (sent[i])
        begin
            @(posedge clk);
            rx <= '{1'b1, i == sent.size() - 1, sent[i]};
        end
        @(posedge clk);
        rx <= '{1'b0, 1'b0, ~sent[sent.size() - 1]};
        for (int n = 0; n < wait_max; n++)
        begin
            @(negedge clk);
            if (tx.valid && tx_ready)
                resp.push_back(tx.data);
            if (tx.valid && tx_ready && tx.last)
                break;
        end
        crc_ok = 1'b0;
        if (resp.size() > 2)
        begin
            body = resp[0:$-2];
            crc_ok = crc16(body) == {resp[$], resp[$-1]};
        end
        @(posedge clk);
    endtask
endmodule

// ===== verif/test_mrs_msg_handler.sv
// self-checking bench of the slave message handler
// assumes the master model shares the 100 MHz clock
`timescale 1ns/100ps

module test_mrs_msg_handler;
    logic                  clk;
    logic                  rstn;
    logic [7:0]            slave_addr;
    logic                  fsel;
    logic                  enter_cmd;
    logic [15:0]           reg_rdata;
    logic                  reg_err;
    logic                  tx_ready;
    logic                  param_dirty;
    mrs_pkg::mrs_byte_s    rx;
    mrs_pkg::mrs_byte_s    tx;
    mrs_pkg::mrs_reg_req_s reg_req;
    logic [33:0]           wlog[$];
    logic [7:0]            exp[$];
    int                    miscompares;
    int                    compares;
    int                    cycles;

    mrs_msg_handler mrs_msg_handler_inst (
        .clk(clk), .rstn(rstn), .slave_addr(slave_addr),
        .enter_function_select(fsel), .enter_cmd(enter_cmd), .rx(rx),
        .tx_ready(tx_ready), .tx(tx), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_err(reg_err), .param_dirty(param_dirty)
    );
    mrs_master_model mrs_master_model_inst (
        .clk(clk), .rx(rx), .tx_ready(tx_ready), .tx(tx)
    );

    // register space: data follows the address, pages above 00FF fault
    always_comb
    begin
        reg_rdata = reg_req.addr ^ 16'h5A00;
        reg_err = reg_req.addr[15:8] != 8'h00;
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (reg_req.wr)
            wlog.push_back({reg_req.space, reg_req.addr, reg_req.wdata});
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            conclude();
        end
    end

    task automatic check(input string what, input logic [33:0] got, exp_v);
        compares = compares + 1;
        if (got !== exp_v)
        begin
            miscompares = miscompares + 1;
            $display("wrong value %s expected %h seen %h", what, exp_v, got);
        end
    endtask

    task automatic expect_resp(input string what);
        check(what, mrs_master_model_inst.resp.size(), exp.size() + 2);
        foreach (exp[i])
            check(what, mrs_master_model_inst.resp[i], exp[i]);
        check(what, mrs_master_model_inst.crc_ok, 1'b1);
    endtask

    task automatic t_read;
        mrs_master_model_inst.slow = 1'b1;
        mrs_master_model_inst.transact('{8'h02, 8'h03, 8'h00, 8'h20,
                                         8'h00, 8'h10}, 400);
        exp = '{8'h02, 8'h03, 8'h20};
        for (int i = 0; i < 16; i++)
        begin
            exp.push_back(8'h5A);
            exp.push_back(8'h20 + 8'(i));
        end
        expect_resp("read16");
        mrs_master_model_inst.slow = 1'b0;
        $display("test read done");
    endtask

    task automatic t_errors;
        mrs_master_model_inst.transact('{8'h02, 8'h03, 8'h00, 8'h20,
                                         8'h00, 8'h11}, 100);
        exp = '{8'h02, 8'h83, 8'h03};
        expect_resp("qty17");
        mrs_master_model_inst.transact('{8'h02, 8'h03, 8'h00, 8'hFF,
                                         8'h00, 8'h02}, 100);
        exp = '{8'h02, 8'h83, 8'h02};
        expect_resp("bad_addr");
        mrs_master_model_inst.transact('{8'h02, 8'h05, 8'h00, 8'h00,
                                         8'h00, 8'h01}, 100);
        exp = '{8'h02, 8'h85, 8'h01};
        expect_resp("bad_func");
        mrs_master_model_inst.transact('{8'h03, 8'h08, 8'h12, 8'h34,
                                         8'h56, 8'h78}, 40);
        check("other_slave", mrs_master_model_inst.resp.size(), 0);
        $display("test errors done");
    endtask

    task automatic t_loop;
        mrs_master_model_inst.transact('{8'h02, 8'h08, 8'h12, 8'h34,
                                         8'hA5, 8'h37}, 100);
        exp = '{8'h02, 8'h08, 8'h12, 8'h34, 8'hA5, 8'h37};
        expect_resp("loop");
        $display("test loopback done");
    endtask

    task automatic t_write;
        fsel <= 1'b1;
        wlog.delete();
        // byte count twice the quantity
        mrs_master_model_inst.transact('{8'h02, 8'h10, 8'h00, 8'h01,
            8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h02, 8'h58}, 100);
        check("wr_n", wlog.size(), 2);
        check("wr0", wlog[0],
              {mrs_pkg::MRS_SPACE_CMD, 32'h0001_0001});
        check("wr1", wlog[1],
              {mrs_pkg::MRS_SPACE_CMD, 32'h0002_0258});
        exp = '{8'h02, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02};
        expect_resp("write");
        check("need_enter", reg_req.need_enter, 1'b1);
        @(negedge clk);
        check("dirty", param_dirty, 1'b1);
        @(posedge clk);
        enter_cmd <= 1'b1;
        @(posedge clk);
        enter_cmd <= 1'b0;
        @(negedge clk);
        check("dirty_clr", param_dirty, 1'b0);
        $display("test write done");
    endtask

    task automatic t_space;
        wlog.delete();
        mrs_master_model_inst.transact('{8'h02, 8'h10, 8'h00, 8'h1F,
            8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02}, 100);
        exp = '{8'h02, 8'h90, 8'h02};
        expect_resp("mon_wr");
        check("mon_wr_n", wlog.size(), 0);
        fsel <= 1'b0;
        mrs_master_model_inst.transact('{8'h00, 8'h10, 8'h00, 8'h03,
            8'h00, 8'h01, 8'h02, 8'h12, 8'h34}, 60);
        check("bc_rsp", mrs_master_model_inst.resp.size(), 0);
        check("bc_wr", wlog[0],
              {mrs_pkg::MRS_SPACE_BCAST, 32'h0003_1234});
        check("bc_ne", reg_req.need_enter, 1'b0);
        check("bc_dirty", param_dirty, 1'b0);
        $display("test space done");
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        rstn = 1'b0;
        slave_addr = 8'h02;
        fsel = 1'b0;
        enter_cmd = 1'b0;
        miscompares = 0;
        compares = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_read;
        t_errors;
        t_loop;
        t_write;
        t_space;
        conclude();
    end
endmodule
